// *** pkg/bsl_regs.svh ***
// Register offsets, field positions, reset values and bus codes of the bus unit status block.
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define BSL_OFS_STATUS 8'h00
`define BSL_OFS_CONTROL 8'h04
`define BSL_OFS_COMMAND 8'h08
`define BSL_OFS_LOCK_LO 8'h0C
`define BSL_OFS_LOCK_HI 8'h10
`define BSL_OFS_IRQ_STAT 8'h14
`define BSL_OFS_IRQ_CLR 8'h18
`define BSL_OFS_IRQ_EN 8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define BSL_STAT_TXREQ_BIT 5
`define BSL_STAT_RXACT_BIT 4
`define BSL_STAT_LOCK_BIT 3
`define BSL_CTRL_RXEN_BIT 0
`define BSL_CMD_TXREQ_BIT 0
`define BSL_CMD_UNLOCK_BIT 1
`define BSL_IRQ_TXREQ_SET 0
`define BSL_IRQ_TX_DONE 1
`define BSL_IRQ_RX_DONE 2
`define BSL_IRQ_LOCK_SET 3

// ****************************************************************
// Reset values, widths and response codes
// ****************************************************************
`define BSL_CTRL_RESET 1'b0
`define BSL_IRQ_COUNT 4
`define BSL_RESP_OKAY 2'h0
`define BSL_RESP_SLVERR 2'h2
`define BSL_ZERO_WORD 32'h0000_0000

`endif

// *** pkg/bsl_pkg.sv ***
// Types shared by the bus unit status block.
package bsl_pkg;

  typedef enum logic [1:0] {
    BSL_TXQ_IDLE,
    BSL_TXQ_WAIT_BUSY,
    BSL_TXQ_WAIT_DONE
  } bsl_txq_e;

  typedef logic [31:0] bsl_word_t;

endpackage

// *** verilog/bsl_flag.sv ***
// One hardware status flag with set and clear inputs.
`timescale 1ns/1ps
module bsl_flag
  import bsl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end

endmodule

// *** verilog/bsl_irq.sv ***
// Sticky interrupt status, enable mask and level interrupt output.
`timescale 1ns/1ps
module bsl_irq
  import bsl_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] event_i,
  input wire logic clr_wr_i,
  input wire logic en_wr_i,
  input wire logic [N-1:0] wdata_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] enable_o,
  output logic irq_o
);

  // Events win over a clear of the same bit in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o <= (status_o & ~(clr_wr_i ? wdata_i : '0)) | event_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_o <= '0;
    end else if (en_wr_i) begin
      enable_o <= wdata_i;
    end
  end

  assign irq_o = |(status_o & enable_o);

endmodule

// *** verilog/bsl_status.sv ***
// Slave transmit request, slave receive and lock status flags with an AXI4-Lite register slave.
// Notes on behaviour
// - Transmit request flag sets when busy flag falls after the transmit request command.
// - Transmit request flag clears when the slave transmission completes.
// - Receive flag sets when slave or broadcast reception starts with receive enabled.
// - Receive flag clears when that reception completes.
// - Lock flag sets when lock control came but announced bytes were not received.
// - Lock flag sets only when message length exceeds the one-frame byte maximum.
// - Lock flag never sets when a frame ends through any other error.
// - Lock flag clears on bus unlock condition or software unlock command.
// - Lock address registers hold a valid master address only while locked.
`timescale 1ns/1ps
`include "bsl_regs.svh"
module bsl_status
  import bsl_pkg::*;
#(
  parameter int MAX_FRAME_BYTES = 32,
  parameter int LEN_W = 12,
  parameter int ADDR_W = 12
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic CMD_EXEC_I,
  input wire logic SLV_TX_DONE_I,
  input wire logic RX_START_I,
  input wire logic RX_DONE_I,
  input wire logic LOCK_CTRL_I,
  input wire logic FRAME_END_I,
  input wire logic BYTES_SHORT_I,
  input wire logic FRAME_ERR_I,
  input wire logic [LEN_W-1:0] MSG_LEN_I,
  input wire logic [ADDR_W-1:0] MASTER_ADDR_I,
  input wire logic UNLOCK_COND_I,
  output logic TX_REQ_CMD_O,
  output logic UNLOCK_CMD_O,
  output logic RX_ENABLE_O,
  output logic SLV_TX_REQ_O,
  output logic SLV_RX_ACTIVE_O,
  output logic UNIT_LOCKED_O,
  output logic IRQ_O
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `BSL_OFS_STATUS) || (a == `BSL_OFS_CONTROL) ||
      (a == `BSL_OFS_COMMAND) || (a == `BSL_OFS_LOCK_LO) ||
      (a == `BSL_OFS_LOCK_HI) || (a == `BSL_OFS_IRQ_STAT) ||
      (a == `BSL_OFS_IRQ_CLR) || (a == `BSL_OFS_IRQ_EN);
  endfunction

  function automatic logic wr_hit(input logic go, input logic [7:0] a,
      input logic [7:0] ofs, input logic lane);
    wr_hit = go && (a == ofs) && lane;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  bsl_word_t rdata_reg;
  bsl_word_t rd_word;
  logic do_write;
  logic ar_take;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic cmd_txreq;
  logic cmd_unlock;
  logic rx_en_reg;
  logic tx_cmd_reg;
  logic unlock_cmd_reg;
  bsl_txq_e txq_reg;
  bsl_txq_e txq_next;
  logic srq_set;
  logic rx_set;
  logic lock_seen_reg;
  logic lock_set;
  logic lock_clr;
  logic [ADDR_W-1:0] lock_addr_reg;
  logic [`BSL_IRQ_COUNT-1:0] irq_events;
  logic [`BSL_IRQ_COUNT-1:0] irq_status;
  logic [`BSL_IRQ_COUNT-1:0] irq_enable;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data are taken in either order; one write at a time.
  assign S_AXI_AWREADY_O = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY_O = !w_hold_reg && !bvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR_I;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= `BSL_ZERO_WORD;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_hold_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA_I;
      wstrb_reg <= S_AXI_WSTRB_I;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `BSL_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_known(awaddr_reg) ? `BSL_RESP_OKAY : `BSL_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;

  // Writes to the status address are accepted and have no effect.
  assign wr_ctrl = wr_hit(do_write, awaddr_reg, `BSL_OFS_CONTROL, wstrb_reg[0]);
  assign wr_cmd = wr_hit(do_write, awaddr_reg, `BSL_OFS_COMMAND, wstrb_reg[0]);
  assign wr_irq_clr = wr_hit(do_write, awaddr_reg, `BSL_OFS_IRQ_CLR, wstrb_reg[0]);
  assign wr_irq_en = wr_hit(do_write, awaddr_reg, `BSL_OFS_IRQ_EN, wstrb_reg[0]);
  assign cmd_txreq = wr_cmd && wdata_reg[`BSL_CMD_TXREQ_BIT];
  assign cmd_unlock = wr_cmd && wdata_reg[`BSL_CMD_UNLOCK_BIT];

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

  always_comb begin
    rd_word = `BSL_ZERO_WORD;
    case (S_AXI_ARADDR_I)
      `BSL_OFS_STATUS: begin
        rd_word[`BSL_STAT_TXREQ_BIT] = SLV_TX_REQ_O;
        rd_word[`BSL_STAT_RXACT_BIT] = SLV_RX_ACTIVE_O;
        rd_word[`BSL_STAT_LOCK_BIT] = UNIT_LOCKED_O;
      end
      `BSL_OFS_CONTROL: begin
        rd_word[`BSL_CTRL_RXEN_BIT] = rx_en_reg;
      end
      // The address reads as zero while unlocked, so stale values never leak.
      `BSL_OFS_LOCK_LO: begin
        rd_word[7:0] = UNIT_LOCKED_O ? lock_addr_reg[7:0] : 8'h00;
      end
      `BSL_OFS_LOCK_HI: begin
        rd_word[ADDR_W-9:0] = UNIT_LOCKED_O ? lock_addr_reg[ADDR_W-1:8] : '0;
      end
      `BSL_OFS_IRQ_STAT: begin
        rd_word[`BSL_IRQ_COUNT-1:0] = irq_status;
      end
      `BSL_OFS_IRQ_EN: begin
        rd_word[`BSL_IRQ_COUNT-1:0] = irq_enable;
      end
      default: begin
        rd_word = `BSL_ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= `BSL_ZERO_WORD;
      rresp_reg <= `BSL_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= addr_known(S_AXI_ARADDR_I) ? `BSL_RESP_OKAY : `BSL_RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;

  // ****************************************************************
  // Control and command strobes
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_en_reg <= `BSL_CTRL_RESET;
    end else if (wr_ctrl) begin
      rx_en_reg <= wdata_reg[`BSL_CTRL_RXEN_BIT];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_cmd_reg <= 1'b0;
      unlock_cmd_reg <= 1'b0;
    end else begin
      tx_cmd_reg <= cmd_txreq;
      unlock_cmd_reg <= cmd_unlock;
    end
  end

  assign RX_ENABLE_O = rx_en_reg;
  assign TX_REQ_CMD_O = tx_cmd_reg;
  assign UNLOCK_CMD_O = unlock_cmd_reg;

  // ****************************************************************
  // Slave transmit request tracking
  // ****************************************************************
  // The flag waits for the engine to raise and then drop its busy flag.
  always_comb begin
    txq_next = txq_reg;
    case (txq_reg)
      BSL_TXQ_IDLE: begin
        if (tx_cmd_reg) begin
          txq_next = BSL_TXQ_WAIT_BUSY;
        end
      end
      BSL_TXQ_WAIT_BUSY: begin
        if (CMD_EXEC_I) begin
          txq_next = BSL_TXQ_WAIT_DONE;
        end
      end
      BSL_TXQ_WAIT_DONE: begin
        if (!CMD_EXEC_I) begin
          txq_next = BSL_TXQ_IDLE;
        end
      end
      default: begin
        txq_next = BSL_TXQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      txq_reg <= BSL_TXQ_IDLE;
    end else begin
      txq_reg <= txq_next;
    end
  end

  assign srq_set = (txq_reg == BSL_TXQ_WAIT_DONE) && !CMD_EXEC_I;

  bsl_flag u_txreq (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .set_i(srq_set),
    .clr_i(SLV_TX_DONE_I),
    .q_o(SLV_TX_REQ_O)
  );

  // ****************************************************************
  // Slave receive tracking
  // ****************************************************************
  assign rx_set = RX_START_I && rx_en_reg;

  bsl_flag u_rxact (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .set_i(rx_set),
    .clr_i(RX_DONE_I),
    .q_o(SLV_RX_ACTIVE_O)
  );

  // ****************************************************************
  // Lock tracking
  // ****************************************************************
  // Frame end wins, so lock bits never leak into the next frame; lock bits in the closing cycle count below.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_seen_reg <= 1'b0;
    end else if (FRAME_END_I) begin
      lock_seen_reg <= 1'b0;
    end else if (LOCK_CTRL_I) begin
      lock_seen_reg <= 1'b1;
    end
  end

  // A frame cut by any other error never locks the unit.
  assign lock_set = FRAME_END_I && (lock_seen_reg || LOCK_CTRL_I) && BYTES_SHORT_I &&
    (int'(MSG_LEN_I) > MAX_FRAME_BYTES) &&
    !FRAME_ERR_I;
  assign lock_clr = UNLOCK_COND_I || unlock_cmd_reg;

  bsl_flag u_lock (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .set_i(lock_set),
    .clr_i(lock_clr),
    .q_o(UNIT_LOCKED_O)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_addr_reg <= '0;
    end else if (lock_set) begin
      lock_addr_reg <= MASTER_ADDR_I;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_events = {lock_set, RX_DONE_I, SLV_TX_DONE_I, srq_set};

  bsl_irq #(
    .N(`BSL_IRQ_COUNT)
  ) u_irq (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .event_i(irq_events),
    .clr_wr_i(wr_irq_clr),
    .en_wr_i(wr_irq_en),
    .wdata_i(wdata_reg[`BSL_IRQ_COUNT-1:0]),
    .status_o(irq_status),
    .enable_o(irq_enable),
    .irq_o(IRQ_O)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  txreq_set_a: assert property (
    (txq_reg == BSL_TXQ_WAIT_DONE) && !CMD_EXEC_I |=> SLV_TX_REQ_O
  ) else $error("Transmit request flag did not set after busy fell.");

  txreq_clr_a: assert property (
    SLV_TX_DONE_I && !srq_set |=> !SLV_TX_REQ_O
  ) else $error("Transmit request flag did not clear on completion.");

  rx_set_a: assert property (
    $rose(SLV_RX_ACTIVE_O) |-> $past(RX_START_I) && $past(rx_en_reg)
  ) else $error("Receive flag rose without an enabled reception start.");

  rx_clr_a: assert property (
    RX_DONE_I && !rx_set |=> !SLV_RX_ACTIVE_O
  ) else $error("Receive flag did not clear at reception end.");

  lock_set_a: assert property (
    FRAME_END_I && (lock_seen_reg || LOCK_CTRL_I) && BYTES_SHORT_I && !FRAME_ERR_I &&
    (int'(MSG_LEN_I) > MAX_FRAME_BYTES) |=> UNIT_LOCKED_O
  ) else $error("Lock flag did not set on a short locking frame.");

  lock_len_a: assert property (
    $rose(UNIT_LOCKED_O) |-> int'($past(MSG_LEN_I)) > MAX_FRAME_BYTES
  ) else $error("Lock flag set with a message length that fits a frame.");

  lock_err_a: assert property (
    FRAME_ERR_I && !UNIT_LOCKED_O |=> !UNIT_LOCKED_O
  ) else $error("Lock flag set by an errored frame.");

  unlock_a: assert property (
    $rose(unlock_cmd_reg) && !lock_set ##0 UNIT_LOCKED_O |=> !UNIT_LOCKED_O
  ) else $error("Lock flag did not clear on the unlock command.");

  lock_addr_a: assert property (
    ar_take && (S_AXI_ARADDR_I == `BSL_OFS_LOCK_LO) && !UNIT_LOCKED_O
    |=> S_AXI_RVALID_O && (S_AXI_RDATA_O == `BSL_ZERO_WORD)
  ) else $error("Lock address visible while unlocked.");

  status_wr_a: assert property (
    do_write && (awaddr_reg == `BSL_OFS_STATUS) && !srq_set && !rx_set && !lock_set
    |=> ($past(SLV_TX_REQ_O) || !SLV_TX_REQ_O) && ($past(UNIT_LOCKED_O) || !UNIT_LOCKED_O)
  ) else $error("A status write set a flag.");

endmodule

// *** tb/bsl_bus_model.sv ***
// Behavioural model of the command engine and the other bus units that feed the status block.
`timescale 1ns/1ps
module bsl_bus_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_req_cmd_i,
  output logic cmd_exec_o,
  output logic slv_tx_done_o,
  output logic rx_start_o,
  output logic rx_done_o,
  output logic lock_ctrl_o,
  output logic frame_end_o,
  output logic bytes_short_o,
  output logic frame_err_o,
  output logic [11:0] msg_len_o,
  output logic [11:0] master_addr_o,
  output logic unlock_cond_o
);
  // ****************************************************************
  // Engine busy time
  // ****************************************************************
  // The bench sets this to make the engine answer promptly or slowly.
  int busy_len = 3;
  int cnt = 0;

  initial begin
    {cmd_exec_o, slv_tx_done_o, rx_start_o, rx_done_o, lock_ctrl_o, frame_end_o} = 6'h00;
    {bytes_short_o, frame_err_o, unlock_cond_o} = 3'h0;
    msg_len_o = 12'h000;
    master_addr_o = 12'h000;
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      cmd_exec_o <= 1'b0;
    end else if (tx_req_cmd_i) begin
      cnt <= busy_len;
      cmd_exec_o <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      cmd_exec_o <= 1'b0;
    end
  end

  // One-cycle bus events: transmission done, reception start and end, unlock condition.
  task automatic ev(input logic txd, input logic rxs, input logic rxd, input logic unl);
    @(posedge clk_i);
    slv_tx_done_o <= txd;
    rx_start_o <= rxs;
    rx_done_o <= rxd;
    unlock_cond_o <= unl;
    @(posedge clk_i);
    {slv_tx_done_o, rx_start_o, rx_done_o, unlock_cond_o} <= 4'h0;
  endtask

  // Frame end with its qualifiers; after it lock control drops and the other qualifiers turn to their inverse, as they are stale.
  task automatic frame(input logic lk, input logic sh, input logic er, input logic [11:0] len,
                       input logic [11:0] adr);
    @(posedge clk_i);
    lock_ctrl_o <= lk;
    frame_end_o <= 1'b1;
    bytes_short_o <= sh;
    frame_err_o <= er;
    msg_len_o <= len;
    master_addr_o <= adr;
    @(posedge clk_i);
    lock_ctrl_o <= 1'b0;
    frame_end_o <= 1'b0;
    bytes_short_o <= ~sh;
    frame_err_o <= ~er;
    msg_len_o <= ~len;
    master_addr_o <= ~adr;
  endtask
endmodule

// *** tb/test_bsl_status.sv ***
// Self-checking testbench of the bus unit status block.
`timescale 1ns/1ps
`include "bsl_regs.svh"
module test_bsl_status;
  localparam int MAXB = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, tx_req_cmd, unlock_cmd, rx_en, f_tx, f_rx, f_lock, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic cmd_exec, tx_done, rx_start, rx_done, lock_ctrl, frame_end, bytes_short, frame_err, unlock_cond;
  logic [11:0] msg_len, master_addr;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  bsl_status #(.MAX_FRAME_BYTES(MAXB), .LEN_W(12), .ADDR_W(12)) u_dut (
    .CLK_I(clk), .RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .CMD_EXEC_I(cmd_exec), .SLV_TX_DONE_I(tx_done), .RX_START_I(rx_start), .RX_DONE_I(rx_done),
    .LOCK_CTRL_I(lock_ctrl), .FRAME_END_I(frame_end), .BYTES_SHORT_I(bytes_short),
    .FRAME_ERR_I(frame_err), .MSG_LEN_I(msg_len), .MASTER_ADDR_I(master_addr),
    .UNLOCK_COND_I(unlock_cond), .TX_REQ_CMD_O(tx_req_cmd), .UNLOCK_CMD_O(unlock_cmd),
    .RX_ENABLE_O(rx_en), .SLV_TX_REQ_O(f_tx), .SLV_RX_ACTIVE_O(f_rx), .UNIT_LOCKED_O(f_lock), .IRQ_O(irq)
  );

  bsl_bus_model u_bus (
    .clk_i(clk), .rst_i(rst), .tx_req_cmd_i(tx_req_cmd), .cmd_exec_o(cmd_exec),
    .slv_tx_done_o(tx_done), .rx_start_o(rx_start), .rx_done_o(rx_done), .lock_ctrl_o(lock_ctrl),
    .frame_end_o(frame_end), .bytes_short_o(bytes_short), .frame_err_o(frame_err),
    .msg_len_o(msg_len), .master_addr_o(master_addr), .unlock_cond_o(unlock_cond)
  );

  // ****************************************************************
  // Reporting and bus cycles
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang must not run forever, so it is cut short and counted.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk(32'(rresp), 32'(er), "read response");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] d;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({f_tx, f_rx, f_lock, irq, rx_en}), 32'h0000_0000, "flags after reset");
    rd(`BSL_OFS_STATUS, `BSL_RESP_OKAY, d);
    chk(d, 32'h0000_0000, "status after reset");
    rd(`BSL_OFS_LOCK_LO, `BSL_RESP_OKAY, d);
    chk(d, 32'h0000_0000, "lock low while unlocked");
  endtask

  task automatic t_soft();
    logic [31:0] d;
    wr(`BSL_OFS_STATUS, 32'hFFFF_FFFF, `BSL_RESP_OKAY);
    rd(`BSL_OFS_STATUS, `BSL_RESP_OKAY, d);
    chk(d, 32'h0000_0000, "status written by software");
    wr(8'h40, 32'h0000_0001, `BSL_RESP_SLVERR);
    rd(8'h40, `BSL_RESP_SLVERR, d);
    chk(d, 32'h0000_0000, "unmapped read data");
    chk(32'(rx_en), 32'h0000_0000, "control after unmapped write");
  endtask

  task automatic t_tx(input int blen);
    int n;
    logic [31:0] d;
    n = 0;
    u_bus.busy_len = blen;
    wr(`BSL_OFS_COMMAND, 32'h0000_0001, `BSL_RESP_OKAY);
    chk(32'(tx_req_cmd), 32'h0000_0001, "transmit request command strobe");
    do begin
      @(posedge clk);
      n++;
      chk(32'(f_tx & cmd_exec), 32'h0000_0000, "request flag while engine busy");
    end while (f_tx !== 1'b1 && n < 60);
    chk(32'(f_tx), 32'h0000_0001, "request flag after engine idle");
    rd(`BSL_OFS_STATUS, `BSL_RESP_OKAY, d);
    chk(32'(d[5]), 32'h0000_0001, "status request bit");
    rd(`BSL_OFS_IRQ_STAT, `BSL_RESP_OKAY, d);
    chk(32'(d[`BSL_IRQ_TXREQ_SET]), 32'h0000_0001, "interrupt status request bit");
    wr(`BSL_OFS_IRQ_EN, 32'h0000_0001, `BSL_RESP_OKAY);
    chk(32'(irq), 32'h0000_0001, "interrupt enabled");
    wr(`BSL_OFS_IRQ_EN, 32'h0000_0000, `BSL_RESP_OKAY);
    chk(32'(irq), 32'h0000_0000, "interrupt masked");
    wr(`BSL_OFS_IRQ_EN, 32'h0000_0001, `BSL_RESP_OKAY);
    wr(`BSL_OFS_IRQ_CLR, 32'h0000_0001, `BSL_RESP_OKAY);
    chk(32'(irq), 32'h0000_0000, "interrupt cleared");
    wr(`BSL_OFS_IRQ_EN, 32'h0000_0000, `BSL_RESP_OKAY);
    u_bus.ev(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    chk(32'(f_tx), 32'h0000_0000, "request flag after transmission");
  endtask

  task automatic t_rx();
    logic [31:0] d;
    u_bus.ev(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    chk(32'(f_rx), 32'h0000_0000, "reception with receive disabled");
    wr(`BSL_OFS_CONTROL, 32'h0000_0001, `BSL_RESP_OKAY);
    u_bus.ev(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    chk(32'(f_rx), 32'h0000_0001, "reception started");
    rd(`BSL_OFS_STATUS, `BSL_RESP_OKAY, d);
    chk(32'(d[4]), 32'h0000_0001, "status receive bit");
    u_bus.ev(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    chk(32'(f_rx), 32'h0000_0000, "reception finished");
  endtask

  task automatic t_lock();
    logic [4:0] lk, sh, er, ex;
    logic [31:0] d;
    lk = 5'b11011;
    sh = 5'b10111;
    er = 5'b00001;
    ex = 5'b10000;
    // Cases: other error, length at the frame maximum, no lock bits, all bytes came, then a real lock.
    for (int i = 0; i < 5; i++) begin
      u_bus.frame(lk[i], sh[i], er[i], (i == 1) ? 12'(MAXB) : 12'(MAXB + 1), 12'hA5C);
      @(posedge clk);
      chk(32'(f_lock), 32'(ex[i]), "lock flag after frame");
    end
    rd(`BSL_OFS_LOCK_LO, `BSL_RESP_OKAY, d);
    chk(d, 32'h0000_005C, "lock address low");
    rd(`BSL_OFS_LOCK_HI, `BSL_RESP_OKAY, d);
    chk(d, 32'h0000_000A, "lock address high");
    u_bus.ev(1'b0, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    chk(32'(f_lock), 32'h0000_0000, "unlock by bus condition");
    u_bus.frame(1'b1, 1'b1, 1'b0, 12'h0FF, 12'h123);
    @(posedge clk);
    chk(32'(f_lock), 32'h0000_0001, "locked again");
    wr(`BSL_OFS_COMMAND, 32'h0000_0002, `BSL_RESP_OKAY);
    chk(32'(unlock_cmd), 32'h0000_0001, "unlock command strobe");
    repeat (3) @(posedge clk);
    chk(32'(f_lock), 32'h0000_0000, "unlock by command");
    rd(`BSL_OFS_LOCK_HI, `BSL_RESP_OKAY, d);
    chk(d, 32'h0000_0000, "lock address after unlock");
  endtask

  initial begin
    t_reset();
    t_soft();
    t_tx(1);
    t_tx(8);
    t_rx();
    t_lock();
    u_bus.frame(1'b1, 1'b1, 1'b0, 12'h0FF, 12'h321);
    t_reset();
    give_verdict();
  end
endmodule
